// ### dv/waveform_sequence_stepper_bench.sv
/*
  Self-checking bench for the sequence stepper: Wishbone register tasks,
  a playback model and an event pin driven by the bench.
  Assumes the stepper answers every bus request within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module waveform_sequence_stepper_bench;
  logic clk_sys, rst_n, cyc, stb, we, ev_pin, seg_end, start, abort, sync, run;
  logic [7:0] adr;
  logic [3:0] sel, sel_q;
  logic [31:0] wdat, rdat, q;
  logic [14:0] seg;
  logic [14:0] starts[$];
  logic [14:0] syncs[$];
  int mismatches, cmp_count, aborts, k;
  int seq_a[9] = '{5, 5, 6, 7, 7, 7, 5, 5, 6};
  logic ack;

  wss_stepper uut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_event_i(ev_pin), .seg_end_i(seg_end), .seg_sel_o(seg),
    .seg_start_o(start), .seg_abort_o(abort), .sync_o(sync), .running_o(run));
  wss_play_model #(.SEG_LEN(4)) model (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .last_pt(seg_end));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (start === 1'b1)
      starts.push_back(seg);
    if (sync === 1'b1)
      syncs.push_back(seg);
    if (abort === 1'b1 && start === 1'b1)
      aborts++;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_seg(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seg got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle: request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= sel_q;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic load_step(input int s, input int loops, input logic hold);
    wb(1'b1, wss_pkg::OFS_TBL_SEG, {hold, 16'h0000, 15'(s)});
    wb(1'b1, wss_pkg::OFS_TBL_LOOPS, 32'(loops));
  endtask

  task automatic ev();
    @(posedge clk_sys);
    ev_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ev_pin <= 1'b0;
  endtask

  task automatic first_after_6(input logic [14:0] exp);
    k = 0;
    while (k < starts.size() && starts[k] === 15'h0006)
      k++;
    chk_seg(k < starts.size() ? starts[k] : 15'h0000, exp);
  endtask

  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    sel_q = 4'hF;
    wdat = 32'h0;
    ev_pin = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    aborts = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b0, wss_pkg::OFS_CTRL, 32'h0);
    chk_reg(q, 32'h0);
    wb(1'b0, wss_pkg::OFS_SYNC_STEP, 32'h0);
    chk_reg(q, 32'h1);
    wb(1'b0, wss_pkg::OFS_PASS, 32'h0);
    chk_reg(q, 32'h1);
    wb(1'b1, wss_pkg::OFS_LENGTH, 32'h2);
    wb(1'b0, wss_pkg::OFS_LENGTH, 32'h0);
    chk_reg(q, 32'h3);
    // only byte 0 enabled: 0x0005 lands; an ignored sel would make 0xFF05 and be refused
    sel_q = 4'h1;
    wb(1'b1, wss_pkg::OFS_LENGTH, 32'h0000FF05);
    sel_q = 4'hF;
    wb(1'b0, wss_pkg::OFS_LENGTH, 32'h0);
    chk_reg(q, 32'h5);
    wb(1'b1, wss_pkg::OFS_LENGTH, 32'h3);
    wb(1'b0, 8'h24, 32'h0);
    chk_reg(q, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, wss_pkg::OFS_CTRL, 32'(m << 1));
      wb(1'b0, wss_pkg::OFS_STATUS, 32'h0);
      chk_reg({30'h0, q[5:4]}, (m < 3) ? 32'(m) : 32'h2);
    end
    $display("test reset_and_modes done");
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, wss_pkg::OFS_TBL_ADDR, 32'h0);
    load_step(5, 2, 1'b0);
    load_step(6, 1, 1'b0);
    load_step(7, 3, 1'b0);
    starts.delete();
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h1);
    repeat (150) @(posedge clk_sys);
    for (int i = 0; i < 9; i++)
      chk_seg(starts[i], 15'(seq_a[i]));
    $display("test free_run done");
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, wss_pkg::OFS_SYNC_STEP, 32'h3);
    wb(1'b1, wss_pkg::OFS_PASS, 32'h2);
    starts.delete();
    syncs.delete();
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h3);
    repeat (250) @(posedge clk_sys);
    chk_reg(32'(starts.size()), 32'd12);
    for (int i = 0; i < 12; i++)
      chk_seg(starts[i], 15'(seq_a[i % 6]));
    chk_reg(32'(syncs.size()), 32'd2);
    chk_seg(syncs[0], 15'h0007);
    wb(1'b0, wss_pkg::OFS_STATUS, 32'h0);
    chk_reg({29'h0, q[2:0]}, 32'h4);
    chk_reg(32'(run), 32'h0);
    $display("test single_pass done");
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, wss_pkg::OFS_TBL_ADDR, 32'h1);
    load_step(6, 1, 1'b1);
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h1);
    repeat (80) @(posedge clk_sys);
    wb(1'b0, wss_pkg::OFS_STATUS, 32'h0);
    chk_reg({29'h0, q[2:0]}, 32'h2);
    chk_reg({17'h0, q[30:16]}, 32'h1);
    chk_reg(32'(run), 32'h1);
    chk_seg(starts[$], 15'h0006);
    starts.delete();
    ev();
    repeat (30) @(posedge clk_sys);
    first_after_6(15'h0007);
    $display("test hold done");
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h9);
    repeat (80) @(posedge clk_sys);
    aborts = 0;
    starts.delete();
    // keep the event edge clear of a segment end, or there is nothing left to cut
    while (seg_end !== 1'b1)
      @(posedge clk_sys);
    ev();
    repeat (30) @(posedge clk_sys);
    chk_reg(32'(aborts), 32'd1);
    first_after_6(15'h0007);
    $display("test abort_switch done");
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, wss_pkg::OFS_CTRL, 32'h5);
    repeat (80) @(posedge clk_sys);
    chk_seg(starts[$], 15'h0005);
    wb(1'b0, wss_pkg::OFS_STATUS, 32'h0);
    chk_reg({29'h0, q[2:0]}, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      ev();
      repeat (60) @(posedge clk_sys);
      chk_seg(starts[$], 15'(seq_a[i * 2 + 2]));
    end
    $display("test event_paced done");
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
endmodule // waveform_sequence_stepper_bench

`default_nettype wire

// ### dv/wss_play_model.sv
/*
  Behavioural playback engine that stands beside the sequence stepper.
  Assumes one clock; a start pulse (re)launches a segment of SEG_LEN points.
*/
`timescale 1ns/1ps
`default_nettype none

module wss_play_model #(
  parameter int SEG_LEN = 4
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rst_n,   // async reset, active low
  input  wire logic start,   // restart segment from first point
  output logic      last_pt  // one-cycle pulse at last point
);
  logic [7:0] cnt_r;
  logic       busy_r;

  // an abort arrives together with a start, so a restart covers both cases
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r   <= 8'h00;
      busy_r  <= 1'b0;
      last_pt <= 1'b0;
    end
    else if (start)
    begin
      cnt_r   <= 8'(SEG_LEN - 1);
      busy_r  <= 1'b1;
      last_pt <= 1'b0;
    end
    else if (busy_r && cnt_r == 8'h00)
    begin
      last_pt <= 1'b1;
      busy_r  <= 1'b0;
    end
    else
    begin
      last_pt <= 1'b0;
      if (busy_r)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // wss_play_model

`default_nettype wire

// ### logic/wss_pkg.sv
/*
  Package for the waveform sequence stepper: register map, field positions,
  reset values, step-table geometry and the advance-mode and state types.
  Assumes a 32-bit classic Wishbone register bus and a 10 MHz system clock.
*/
`default_nettype none

package wss_pkg;

  // table geometry
  localparam int unsigned TBL_DEPTH    = 32768;
  localparam int unsigned IDX_W        = 15;
  localparam int unsigned SEG_W        = 15;
  localparam int unsigned LOOP_W       = 20;
  localparam int unsigned LEN_W        = 16;
  localparam logic [LEN_W-1:0]  LEN_MIN = 16'h0003;
  localparam logic [LEN_W-1:0]  LEN_MAX = 16'h8000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_LENGTH    = 8'h08;
  localparam logic [7:0] OFS_PASS      = 8'h0C;
  localparam logic [7:0] OFS_SYNC_STEP = 8'h10;
  localparam logic [7:0] OFS_TBL_ADDR  = 8'h14;
  localparam logic [7:0] OFS_TBL_SEG   = 8'h18;
  localparam logic [7:0] OFS_TBL_LOOPS = 8'h1C;
  localparam logic [7:0] OFS_LOOP_LEFT = 8'h20;

  // control field positions
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_MODE_LSB  = 1;
  localparam int unsigned CTRL_ABORT_BIT = 3;
  // table segment word: hold flag in the top bit
  localparam int unsigned SEG_HOLD_BIT   = 31;
  // status field positions
  localparam int unsigned ST_STATE_LSB   = 0;
  localparam int unsigned ST_MODE_LSB    = 4;
  localparam int unsigned ST_PEND_BIT    = 6;
  localparam int unsigned ST_IDX_LSB     = 16;

  // reset values
  localparam logic [LOOP_W-1:0] PASS_RST = 20'h00001;
  localparam logic [LEN_W-1:0]  SYNC_RST = 16'h0001;
  localparam logic [LEN_W-1:0]  LEN_RST  = 16'h0003;

  typedef enum logic [1:0] {WSS_ADV_FREE, WSS_ADV_ONCE, WSS_ADV_EVENT} wss_adv_t;
  typedef enum logic [2:0] {WSS_IDLE, WSS_PLAY, WSS_HOLD, WSS_WAIT_EV, WSS_DONE} wss_state_t;

  typedef struct packed {
    logic              hold;
    logic [LOOP_W-1:0] loops;
    logic [SEG_W-1:0]  seg;
  } wss_step_t;

endpackage : wss_pkg

`default_nettype wire

// ### logic/wss_stepper.sv
/*
  Waveform sequence stepper: walks a step table (segment, loop count, hold
  flag) in free-running, single-pass or event-paced advance, and tells the
  segment playback engine which segment to play and when to (re)start it.
  Assumes seg_end_i is a one-cycle pulse on clk_sys from the playback engine
  at the last point of the playing segment; ext_event_i is an asynchronous pin.
*/
// Behaviour
// - free mode plays steps in order, wraps to step 1 forever, unless held
// - loop count n above 1 plays the step segment n times, then advances
// - in free and single-pass modes a hold flag blocks advance until an event
// - single-pass plays the table once then stops, idling on a waveform
// - single-pass pass count n above 1 plays whole sequence n times, max 1048575
// - event mode advances only on events; after last step events restart sequence
// - event mode ignores hold flags; each event plays the step n loops
// - advance mode readable as free, single-pass or event; reset gives free
// - sync marker emitted at programmable step position, reset value step 1
// - table holds 3 to 32768 steps, numbered from 1 in load order
// - hold flag 0 advances normally, 1 dwells until a valid event
// - per-step loop count ranges 1 to 1048575
// - end-point switch waits for segment end; abort switch cuts at once
`timescale 1ns/1ps
`default_nettype none

module wss_stepper (
  input  wire logic                        clk_sys,     // 10 MHz system clock
  input  wire logic                        rst_n,       // async reset, active low
  input  wire logic                        wb_cyc_i,    // wishbone cycle
  input  wire logic                        wb_stb_i,    // wishbone strobe
  input  wire logic                        wb_we_i,     // wishbone write enable
  input  wire logic [7:0]                  wb_adr_i,    // wishbone byte address
  input  wire logic [3:0]                  wb_sel_i,    // wishbone byte enables
  input  wire logic [31:0]                 wb_dat_i,    // wishbone write data
  output logic      [31:0]                 wb_dat_o,    // wishbone read data
  output logic                             wb_ack_o,    // wishbone acknowledge
  input  wire logic                        ext_event_i, // external event pin
  input  wire logic                        seg_end_i,   // playing segment at last point
  output logic      [wss_pkg::SEG_W-1:0]   seg_sel_o,   // segment to play
  output logic                             seg_start_o, // start segment from first point
  output logic                             seg_abort_o, // cut current segment now
  output logic                             sync_o,      // sync marker pulse
  output logic                             running_o    // sequence active
);

  wss_pkg::wss_step_t  tbl_r [wss_pkg::TBL_DEPTH];
  wss_pkg::wss_adv_t   mode_r;
  wss_pkg::wss_state_t state_r;
  logic                run_r, abort_sw_r, ack_r, ev_pend_r, running_r;
  logic                ev_s1_r, ev_s2_r, ev_s3_r;
  logic                start_r, abort_r, sync_r;
  logic [15:0]         len_r, sync_step_r;
  logic [19:0]         pass_cfg_r, loop_r, pass_r;
  logic [14:0]         tbl_addr_r, idx_r, seg_r;
  logic [31:0]         stage_seg_r, rdat_r;

  logic                wr_en, ev_edge, release_ev, last_step, done_once, adv_go, adv_cut;
  logic [31:0]         bmask;
  logic [14:0]         idx_nxt;
  wss_pkg::wss_step_t  ent_nxt, ent_first;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] neu,
                                        input logic [31:0] m);
    merge = (old & ~m) | (neu & m);
  endfunction

  // bus slave: one wait state, ack on the second edge of the request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r       <= 1'b0;
      mode_r      <= wss_pkg::WSS_ADV_FREE;
      abort_sw_r  <= 1'b0;
      len_r       <= wss_pkg::LEN_RST;
      pass_cfg_r  <= wss_pkg::PASS_RST;
      sync_step_r <= wss_pkg::SYNC_RST;
      tbl_addr_r  <= 15'h0000;
      stage_seg_r <= 32'h00000000;
    end
    else if (wr_en)
    begin
      unique case (wb_adr_i)
        wss_pkg::OFS_CTRL:
        begin
          logic [31:0] c;
          c = merge({28'h0000000, abort_sw_r, mode_r, run_r}, wb_dat_i, bmask);
          run_r      <= c[wss_pkg::CTRL_RUN_BIT];
          abort_sw_r <= c[wss_pkg::CTRL_ABORT_BIT];
          // code 3 names no mode, so the write leaves the mode alone
          if (c[wss_pkg::CTRL_MODE_LSB +: 2] != 2'h3)
            mode_r <= wss_pkg::wss_adv_t'(c[wss_pkg::CTRL_MODE_LSB +: 2]);
        end
        wss_pkg::OFS_LENGTH:
        begin
          logic [31:0] l;
          l = merge({16'h0000, len_r}, wb_dat_i, bmask);
          // out-of-range lengths are dropped so the walk never leaves the table
          if (l[31:16] == 16'h0000 && l[15:0] >= wss_pkg::LEN_MIN && l[15:0] <= wss_pkg::LEN_MAX)
            len_r <= l[15:0];
        end
        wss_pkg::OFS_PASS:
          if (20'(merge({12'h000, pass_cfg_r}, wb_dat_i, bmask)) != 20'h00000)
            pass_cfg_r <= 20'(merge({12'h000, pass_cfg_r}, wb_dat_i, bmask));
        wss_pkg::OFS_SYNC_STEP:
          sync_step_r <= 16'(merge({16'h0000, sync_step_r}, wb_dat_i, bmask));
        wss_pkg::OFS_TBL_ADDR:
          tbl_addr_r <= 15'(merge({17'h00000, tbl_addr_r}, wb_dat_i, bmask));
        wss_pkg::OFS_TBL_SEG:
          stage_seg_r <= merge(stage_seg_r, wb_dat_i, bmask);
        wss_pkg::OFS_TBL_LOOPS:
          tbl_addr_r <= tbl_addr_r + 15'h0001;
        default:
          ;
      endcase
    end
  end

  // table entry commit on the loop-count write; steps load in ascending order
  always_ff @(posedge clk_sys)
  begin
    if (wr_en && wb_adr_i == wss_pkg::OFS_TBL_LOOPS)
      tbl_r[tbl_addr_r] <= '{hold: stage_seg_r[wss_pkg::SEG_HOLD_BIT],
                             loops: wb_dat_i[19:0] & bmask[19:0],
                             seg: stage_seg_r[14:0]};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdat_r <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
    begin
      unique case (wb_adr_i)
        wss_pkg::OFS_CTRL:      rdat_r <= {28'h0000000, abort_sw_r, mode_r, run_r};
        wss_pkg::OFS_STATUS:    rdat_r <= {1'b0, idx_r, 9'h000, ev_pend_r, mode_r, 1'b0, state_r};
        wss_pkg::OFS_LENGTH:    rdat_r <= {16'h0000, len_r};
        wss_pkg::OFS_PASS:      rdat_r <= {12'h000, pass_cfg_r};
        wss_pkg::OFS_SYNC_STEP: rdat_r <= {16'h0000, sync_step_r};
        wss_pkg::OFS_TBL_ADDR:  rdat_r <= {17'h00000, tbl_addr_r};
        wss_pkg::OFS_TBL_SEG:   rdat_r <= stage_seg_r;
        wss_pkg::OFS_LOOP_LEFT: rdat_r <= {12'h000, loop_r};
        default:                rdat_r <= 32'h00000000;
      endcase
    end
  end

  // event pin: two-flop synchroniser, third flop only for the edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end
    else
    begin
      ev_s1_r <= ext_event_i;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  assign ev_edge    = ev_s2_r && !ev_s3_r;
  assign release_ev = ev_edge || ev_pend_r;
  assign last_step  = ({1'b0, idx_r} + 16'h0001) >= len_r;
  assign idx_nxt    = last_step ? 15'h0000 : idx_r + 15'h0001;
  assign done_once  = last_step && mode_r == wss_pkg::WSS_ADV_ONCE && pass_r <= 20'h00001;
  assign ent_nxt    = tbl_r[idx_nxt];
  assign ent_first  = tbl_r[0];

  // advance fires at segment end, or at once on an event under abort switching
  always_comb
  begin
    adv_go  = 1'b0;
    adv_cut = 1'b0;
    unique case (state_r)
      wss_pkg::WSS_PLAY:
        adv_go = seg_end_i && loop_r <= 20'h00001 && mode_r != wss_pkg::WSS_ADV_EVENT
                 && !tbl_r[idx_r].hold;
      wss_pkg::WSS_HOLD, wss_pkg::WSS_WAIT_EV:
      begin
        adv_go  = release_ev && (seg_end_i || abort_sw_r);
        adv_cut = release_ev && abort_sw_r && !seg_end_i;
      end
      default:
        ;
    endcase
  end

  // a pending event is held only while a step waits; set wins over consume
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ev_pend_r <= 1'b0;
    else if (state_r != wss_pkg::WSS_HOLD && state_r != wss_pkg::WSS_WAIT_EV)
      ev_pend_r <= 1'b0;
    else if (ev_edge && !(adv_go && !ev_pend_r))
      ev_pend_r <= 1'b1;
    else if (adv_go)
      ev_pend_r <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= wss_pkg::WSS_IDLE;
      idx_r   <= 15'h0000;
      loop_r  <= 20'h00000;
      pass_r  <= 20'h00000;
      seg_r   <= 15'h0000;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      sync_r  <= 1'b0;
      running_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
      sync_r  <= 1'b0;
      // follows the next state, so the pin is a flop and not a state decode
      running_r <= run_r && (state_r == wss_pkg::WSS_IDLE || (state_r != wss_pkg::WSS_DONE && !(adv_go && done_once)));
      if (!run_r)
        state_r <= wss_pkg::WSS_IDLE;
      else
      begin
        unique case (state_r)
          wss_pkg::WSS_IDLE:
          begin
            idx_r   <= 15'h0000;
            loop_r  <= ent_first.loops;
            pass_r  <= pass_cfg_r;
            seg_r   <= ent_first.seg;
            start_r <= 1'b1;
            sync_r  <= sync_step_r == 16'h0001;
            state_r <= wss_pkg::WSS_PLAY;
          end
          wss_pkg::WSS_PLAY:
          begin
            if (seg_end_i)
            begin
              start_r <= 1'b1;
              if (loop_r > 20'h00001)
                loop_r <= loop_r - 20'h00001;
              else if (mode_r == wss_pkg::WSS_ADV_EVENT)
                state_r <= wss_pkg::WSS_WAIT_EV;
              else if (tbl_r[idx_r].hold)
                state_r <= wss_pkg::WSS_HOLD;
            end
          end
          wss_pkg::WSS_HOLD, wss_pkg::WSS_WAIT_EV:
          begin
            // the waiting step keeps replaying its segment
            if (seg_end_i)
              start_r <= 1'b1;
          end
          wss_pkg::WSS_DONE:
            ;
        endcase
        if (adv_go)
        begin
          start_r <= 1'b1;
          abort_r <= adv_cut;
          if (done_once)
          begin
            // run mode outside picks the idle waveform; we stay on the last one
            state_r <= wss_pkg::WSS_DONE;
            start_r <= 1'b0;
            abort_r <= 1'b0;
          end
          else
          begin
            if (last_step && mode_r == wss_pkg::WSS_ADV_ONCE)
              pass_r <= pass_r - 20'h00001;
            idx_r   <= idx_nxt;
            loop_r  <= ent_nxt.loops;
            seg_r   <= ent_nxt.seg;
            sync_r  <= ({1'b0, idx_nxt} + 16'h0001) == sync_step_r;
            state_r <= wss_pkg::WSS_PLAY;
          end
        end
      end
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign seg_sel_o   = seg_r;
  assign seg_start_o = start_r;
  assign seg_abort_o = abort_r;
  assign sync_o      = sync_r;
  assign running_o   = running_r;

  a_loop_repeat: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && state_r == wss_pkg::WSS_PLAY && seg_end_i && loop_r > 20'h00001 && !adv_go
    |=> loop_r == $past(loop_r) - 20'h00001 && idx_r == $past(idx_r) && start_r)
    else $error("loop count not stepped down on segment end");
  a_free_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && adv_go && last_step && mode_r == wss_pkg::WSS_ADV_FREE
    |=> idx_r == 15'h0000 && state_r == wss_pkg::WSS_PLAY)
    else $error("free mode did not wrap to first step");
  a_hold_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == wss_pkg::WSS_HOLD && !release_ev && run_r
    |=> idx_r == $past(idx_r) && state_r == wss_pkg::WSS_HOLD)
    else $error("held step advanced without event");
  a_once_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && adv_go && done_once |=> state_r == wss_pkg::WSS_DONE && !start_r [*2])
    else $error("single pass did not stop after last step");
  a_pass_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && adv_go && last_step && mode_r == wss_pkg::WSS_ADV_ONCE && pass_r > 20'h00001
    |=> pass_r == $past(pass_r) - 20'h00001 && idx_r == 15'h0000)
    else $error("pass count not consumed at sequence end");
  a_event_pace: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == wss_pkg::WSS_WAIT_EV && !release_ev ##1 state_r == wss_pkg::WSS_WAIT_EV
    |-> idx_r == $past(idx_r, 2))
    else $error("event mode advanced without event");
  a_event_nohold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && mode_r == wss_pkg::WSS_ADV_EVENT && state_r == wss_pkg::WSS_PLAY && seg_end_i
    && loop_r <= 20'h00001 |=> state_r == wss_pkg::WSS_WAIT_EV)
    else $error("event mode step not waiting for event");
  a_sync_place: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_o |-> seg_start_o && ({1'b0, idx_r} + 16'h0001) == sync_step_r && state_r == wss_pkg::WSS_PLAY)
    else $error("sync marker off its step");
  a_abort_cut: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && abort_sw_r && state_r == wss_pkg::WSS_HOLD && ev_edge && !seg_end_i && !done_once
    |=> seg_abort_o && seg_start_o && idx_r != $past(idx_r))
    else $error("abort switch did not cut at once");
  a_endpt_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && !abort_sw_r && state_r == wss_pkg::WSS_HOLD && !seg_end_i
    |=> !seg_abort_o && idx_r == $past(idx_r))
    else $error("end-point switch jumped before segment end");
  a_start_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_r && state_r == wss_pkg::WSS_IDLE
    |=> idx_r == 15'h0000 && loop_r == $past(ent_first.loops) && seg_start_o)
    else $error("start did not load first step");

endmodule // wss_stepper

`default_nettype wire
